// ==== verif/epw_eeprom_model.sv ====
// Behavioural byte-wide EEPROM seen by the host controller.
// Assumes 1ns time units; programming time is shortened to PROG_NS.
`timescale 1ns/10ps
`default_nettype none
module epw_eeprom_model #(
  parameter int PROG_NS = 20000
) (
  // Strobes
  input  wire logic        ce_n,
  input  wire logic        oe_n,
  input  wire logic        we_n,
  // Bus
  input  wire logic [12:0] addr,
  input  wire logic [7:0]  dq_out,
  output logic [7:0]       dq_in
);
  logic [7:0]  mem [8192];
  logic [7:0]  pbuf [64];
  logic [63:0] pmask = '0;
  logic [12:0] wa, last_a;
  logic [7:0]  last_d, rd, held = 8'h00;
  logic        busy = 0, loading = 0, tog = 0;
  realtime     t_fall;
  initial foreach (mem[i]) mem[i] = 8'hFF;
  //////////////////////////////////////////////////////////////////////////
  always @(negedge ce_n or negedge we_n)
    if (!ce_n && !we_n && oe_n && !busy) begin
      wa = addr;
      t_fall = $realtime;
      loading = 1;
    end
  // Only the first rising strobe takes data
  always @(posedge ce_n or posedge we_n)
    if (oe_n && loading && !busy && ce_n != we_n) begin
      pbuf[wa[5:0]] = dq_out;
      pmask[wa[5:0]] = 1'b1;
      last_a = wa;
      last_d = dq_out;
    end
  initial forever begin
    wait (loading);
    while ($realtime - t_fall < 150000.0) #100;
    busy = 1;
    loading = 0;
    #(PROG_NS);
    for (int i = 0; i < 64; i++)
      if (pmask[i]) mem[{last_a[12:6], i[5:0]}] = pbuf[i];
    pmask = '0;
    busy = 0;
  end
  always @(negedge oe_n or negedge ce_n)
    if (!ce_n && !oe_n && busy) tog = !tog;
  // Busy reads show status, idle reads the array
  assign rd = busy ? {~last_d[7], tog, last_d[5:0]} : mem[addr];
  // A floating bus never repeats the last value seen
  always @* begin
    if (!ce_n && !oe_n) begin
      dq_in = rd;
      held = rd;
    end else dq_in = ~held;
  end
endmodule
`default_nettype wire

// ==== verif/epw_host_props.sv ====
// Pin protocol checker for the host controller.
// Assumes the bind below attaches it to every host instance.
`timescale 1ns/10ps
`default_nettype none
module epw_host_props (
  input wire logic        clock,
  input wire logic        arst_n,
  input wire logic        ce_n_q,
  input wire logic        oe_n_q,
  input wire logic        we_n_q,
  input wire logic [12:0] addr_q,
  input wire logic        dq_oe_q
);
  logic [15:0] cnt_q;
  logic [6:0]  page_q;
  logic        we_q;
  // Cycles since the last write strobe fall, saturating
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= 16'hFFFF;
      page_q <= 7'h00;
      we_q <= 1'b1;
    end else begin
      we_q <= we_n_q;
      if (we_q && !we_n_q) begin
        cnt_q <= 16'h0000;
        page_q <= addr_q[12:6];
      end else if (cnt_q != 16'hFFFF) cnt_q <= cnt_q + 16'h0001;
    end
  end
  a_write_oe_high: assert property (@(posedge clock) disable iff (!arst_n)
    !ce_n_q && !we_n_q |-> oe_n_q) else $error("write with output enable low");
  a_oe_between: assert property (@(posedge clock) disable iff (!arst_n)
    !oe_n_q |-> !dq_oe_q && we_n_q) else $error("read overlaps a write");
  a_load_form: assert property (@(posedge clock) disable iff (!arst_n)
    $fell(we_n_q) |-> !ce_n_q && dq_oe_q) else $error("bad byte load form");
  a_data_valid: assert property (@(posedge clock) disable iff (!arst_n)
    $rose(we_n_q) |-> $past(dq_oe_q) && !ce_n_q) else $error("data gone at rise");
  a_page_same: assert property (@(posedge clock) disable iff (!arst_n)
    $fell(we_n_q) && cnt_q < 16'd5900 |-> addr_q[12:6] == page_q)
    else $error("page address changed inside a page");
endmodule
bind epw_host epw_host_props u_props (
  .clock  (clock),
  .arst_n (arst_n),
  .ce_n_q (ce_n_q),
  .oe_n_q (oe_n_q),
  .we_n_q (we_n_q),
  .addr_q (addr_q),
  .dq_oe_q(dq_oe_q)
);
`default_nettype wire

// ==== verif/testbench.sv ====
// Self-checking bench: host controller against the EEPROM model.
// Assumes the 6000-cycle load window of the controller.
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import epw_pkg::*;
  logic clock = 0, arst_n = 0, req_valid = 0;
  epw_req_s req = '0;
  logic req_ready_q, rsp_valid_q, done_q, page_err_q;
  logic ce_n_q, oe_n_q, we_n_q, dq_oe_q;
  logic [DATA_W-1:0] rsp_data_q, dq_out_q, dq_in;
  logic [ADDR_W-1:0] addr_q;
  int mismatches = 0, n_compared = 0;
  initial forever #12.5 clock = ~clock;
  epw_host DUT (.clock, .arst_n, .req_valid, .req, .req_ready_q,
    .rsp_valid_q, .rsp_data_q, .done_q, .page_err_q, .ce_n_q, .oe_n_q,
    .we_n_q, .addr_q, .dq_out_q, .dq_oe_q, .dq_in);
  epw_eeprom_model dev (.ce_n(ce_n_q), .oe_n(oe_n_q), .we_n(we_n_q),
    .addr(addr_q), .dq_out(dq_out_q), .dq_in(dq_in));
  //////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [7:0] exp, got);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic conclude;
    $display("compared %0d mismatched %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic send(input epw_cmd_e c, input logic [12:0] a,
                      input logic [7:0] d);
    int i;
    i = 0;
    @(negedge clock);
    req_valid = 1;
    req = '{c, a, d, 1'b0};
    while (req_ready_q !== 1'b1 && i < 9000) begin
      @(negedge clock);
      i++;
    end
    if (i == 9000) begin
      check("ready timeout", 8'h01, 8'h00);
      conclude;
    end
    @(negedge clock);
    req_valid = 0;
  endtask
  // Waits up to n cycles for a flag value, returns cycles spent
  task automatic await(input int sel, input int n, output int i);
    i = 0;
    while ((sel ? done_q !== 1'b0 : rsp_valid_q !== 1'b1) && i < n) begin
      @(negedge clock);
      i++;
    end
    if (i == n) begin
      check("wait timeout", 8'h01, 8'h00);
      conclude;
    end
  endtask
  task automatic access(input epw_cmd_e c, input logic [12:0] a,
                        input logic [7:0] exp);
    int i;
    send(c, a, 8'h00);
    await(0, 20000, i);
    check(c == EPW_CMD_POLL ? "poll data" : "read data", exp, rsp_data_q);
  endtask
  //////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    check("idle pins", 8'h1D, {3'b0, ce_n_q, oe_n_q, we_n_q, dq_oe_q, done_q});
  endtask
  // Three loads in one page, two at its boundaries, then close, poll and read back
  task automatic t_page;
    int i;
    send(EPW_CMD_WRITE, 13'h0140, 8'hA5);
    send(EPW_CMD_WRITE, 13'h017F, 8'h3C);
    send(EPW_CMD_WRITE, 13'h0155, 8'h5A);
    check("page error", 8'h00, {7'b0, page_err_q});
    await(1, 7000, i);
    check("close window", 8'h01, {7'b0, i >= 5900 && i <= 6010});
    access(EPW_CMD_POLL, 13'h0155, 8'h5A);
    check("done after poll", 8'h01, {7'b0, done_q});
    access(EPW_CMD_READ, 13'h0140, 8'hA5);
    access(EPW_CMD_READ, 13'h017F, 8'h3C);
    access(EPW_CMD_READ, 13'h0155, 8'h5A);
    access(EPW_CMD_READ, 13'h0141, 8'hFF);
  endtask
  // Single byte at the top address with bit 7 set
  task automatic t_byte;
    int i;
    send(EPW_CMD_WRITE, 13'h1FFF, 8'h80);
    check("page error new page", 8'h00, {7'b0, page_err_q});
    await(1, 7000, i);
    access(EPW_CMD_POLL, 13'h1FFF, 8'h80);
    access(EPW_CMD_READ, 13'h1FFF, 8'h80);
    access(EPW_CMD_READ, 13'h017F, 8'h3C);
  endtask
  initial begin
    repeat (2) @(negedge clock);
    t_reset;
    arst_n = 1;
    @(negedge clock);
    t_page;
    t_byte;
    conclude;
  end
endmodule
`default_nettype wire

// ==== verilog/epw_counter.sv ====
// Down counter for phase timing.
// Assumes one clock and an active-low asynchronous reset.
`timescale 1ns/10ps
`default_nettype none
module epw_counter
  import epw_pkg::*;
(
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             arst_n,
  // Control
  input  wire logic             load,
  input  wire logic [CNT_W-1:0] value,
  // Status
  output logic                  done
);
  logic [CNT_W-1:0] cnt_q;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= '0;
    end else if (load) begin
      cnt_q <= value;
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - CNT_W'(1);
    end
  end

  // Depends on the count only: callers load on done, so a term in load
  // would close a combinational loop
  assign done = (cnt_q == '0);
endmodule
`default_nettype wire

// ==== verilog/epw_host.sv ====
// Host controller driving an 8K x 8 parallel EEPROM through its pins.
// Assumes the pins are sampled synchronously to clock.
//
// Contract
// (RULE_01) Device drives data only while chip select and output enable low.
// (RULE_02) Device floats data when chip select or output enable is high.
// (RULE_03) Write begins with select and write enable low, output enable high.
// (RULE_04) Address taken on the later falling edge of select or write enable.
// (RULE_05) Data taken on the earlier rising edge of select or write enable.
// (RULE_06) A started byte write programs to completion without host action.
// (RULE_07) One to 64 byte loads commit together in one programming cycle.
// (RULE_08) Host keeps page address bits equal across all loads of a page. The code passes req.addr through and only flags a change in page_err_q.
// (RULE_09) Low six address bits pick the byte within the page.
// (RULE_10) Any write may grow to a page of up to 63 more bytes.
// (RULE_11) Host starts each next load within 150 us of previous write fall.
// (RULE_12) Programming starts when no write fall is seen for 150 us.
// (RULE_13) While busy, reading last byte returns inverted bit 7.
// (RULE_14) When done, reading last byte returns true bit 7.
// (RULE_15) Blocked protected writes give no bit 7 completion indication.
// (RULE_16) While busy, bit 6 inverts on every successive read.
// (RULE_17) When done, bit 6 stops toggling and accesses resume.
// (RULE_18) Mixed page addresses within a page give undefined destination.
// (RULE_19) Host may pulse output enable between page loads to poll.
// (RULE_20) Protection enable takes effect at end of programming period.
// (RULE_21) Writes during programming are ignored by the device.
// (RULE_22) Byte load timeout is real time from each write fall.
`timescale 1ns/10ps
`default_nettype none
module epw_host
  import epw_pkg::*;
(
  // Clock and reset
  input  wire logic              clock,
  input  wire logic              arst_n,
  // User request
  input  wire logic              req_valid,
  input  wire epw_req_s          req,
  output logic                   req_ready_q,
  // User answer
  output logic                   rsp_valid_q,
  output logic [DATA_W-1:0]      rsp_data_q,
  output logic                   done_q,
  output logic                   page_err_q,
  // Device pins
  output logic                   ce_n_q,
  output logic                   oe_n_q,
  output logic                   we_n_q,
  output logic [ADDR_W-1:0]      addr_q,
  output logic [DATA_W-1:0]      dq_out_q,
  output logic                   dq_oe_q,
  input  wire logic [DATA_W-1:0] dq_in
);

  typedef enum logic [6:0] {
    ST_IDLE  = 7'h01,
    ST_RSET  = 7'h02,
    ST_RACC  = 7'h04,
    ST_WSET  = 7'h08,
    ST_WPUL  = 7'h10,
    ST_GAP   = 7'h20,
    ST_POLL  = 7'h40
  } epw_state_e;

  epw_state_e        st_q;
  epw_cmd_e          cmd_q;
  logic              in_page_q;
  logic              last_q;
  logic [ADDR_W-PAGE_LSB-1:0] page_q;
  logic [DATA_W-1:0] last_data_q;
  logic [DATA_W-1:0] prev_rd_q;
  logic              have_prev_q;
  logic              tmr_load;
  logic [CNT_W-1:0]  tmr_val;
  logic              tmr_done;
  logic              win_load;
  logic              win_done;

  ////////////////////////////////////////////////////////////////////////////
  // Phase timer and byte load window timer

  epw_counter u_phase (
    .clock  (clock),
    .arst_n (arst_n),
    .load   (tmr_load),
    .value  (tmr_val),
    .done   (tmr_done)
  );

  // Restarted on every write-enable fall: the device times from there
  epw_counter u_window (
    .clock  (clock),
    .arst_n (arst_n),
    .load   (win_load),
    .value  (CNT_W'(LOAD_WINDOW_CYC)),
    .done   (win_done)
  ); // [RULE_11] [RULE_22]

  assign win_load = (st_q == ST_WSET) && tmr_done;

  always_comb begin
    tmr_load = 1'b0;
    tmr_val  = '0;
    case (st_q)
      ST_IDLE: begin
        if (req_valid && req_ready_q) begin
          tmr_load = 1'b1;
          tmr_val  = CNT_W'(SETUP_CYC);
        end
      end
      ST_RSET: begin
        if (tmr_done) begin
          tmr_load = 1'b1;
          tmr_val  = CNT_W'(ACCESS_CYC);
        end
      end
      ST_WSET: begin
        if (tmr_done) begin
          tmr_load = 1'b1;
          tmr_val  = CNT_W'(WE_PULSE_CYC);
        end
      end
      ST_RACC, ST_WPUL: begin
        if (tmr_done) begin
          tmr_load = 1'b1;
          tmr_val  = CNT_W'(GAP_CYC);
        end
      end
      // A repeated poll read needs its own select setup time
      ST_GAP: begin
        if (tmr_done && cmd_q == EPW_CMD_POLL && !done_q) begin
          tmr_load = 1'b1;
          tmr_val  = CNT_W'(SETUP_CYC);
        end
      end
      default: begin
        tmr_load = 1'b0;
        tmr_val  = '0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      st_q  <= ST_IDLE;
      cmd_q <= EPW_CMD_READ;
    end else begin
      case (st_q)
        ST_IDLE: begin
          if (req_valid && req_ready_q) begin
            cmd_q <= req.cmd;
            st_q  <= (req.cmd == EPW_CMD_WRITE) ? ST_WSET : ST_RSET;
          end else if (in_page_q && win_done) begin
            st_q <= ST_POLL; // [RULE_12]
          end
        end
        ST_RSET: if (tmr_done) st_q <= ST_RACC;
        ST_RACC: if (tmr_done) st_q <= ST_GAP;
        ST_WSET: if (tmr_done) st_q <= ST_WPUL;
        ST_WPUL: if (tmr_done) st_q <= ST_GAP;
        ST_GAP: begin
          if (tmr_done) begin
            st_q <= (cmd_q == EPW_CMD_POLL && !done_q) ? ST_RSET : ST_IDLE;
          end
        end
        // Page closed by the device itself; clear done and return to idle for poll requests
        ST_POLL: st_q <= ST_IDLE;
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // New requests are held off while a poll loop runs
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      req_ready_q <= 1'b0;
    end else begin
      req_ready_q <= (st_q == ST_IDLE) && !(req_valid && req_ready_q)
                     && !(in_page_q && win_done);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pins

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ce_n_q   <= 1'b1;
      oe_n_q   <= 1'b1;
      we_n_q   <= 1'b1;
      addr_q   <= '0;
      dq_out_q <= '0;
      dq_oe_q  <= 1'b0;
    end else begin
      case (st_q)
        ST_IDLE: begin
          if (req_valid && req_ready_q) begin
            addr_q   <= req.addr; // [RULE_09]
            dq_out_q <= req.data;
            ce_n_q   <= 1'b0;
            oe_n_q   <= 1'b1; // [RULE_03]
            dq_oe_q  <= (req.cmd == EPW_CMD_WRITE);
          end
        end
        ST_RSET: begin
          if (tmr_done) oe_n_q <= 1'b0; // [RULE_01] [RULE_19]
        end
        ST_WSET: begin
          // Address settled before the later fall, on write enable
          if (tmr_done) we_n_q <= 1'b0; // [RULE_03] [RULE_04]
        end
        ST_RACC, ST_WPUL: begin
          // Write enable rises first so data is taken on it
          if (tmr_done) begin
            we_n_q <= 1'b1; // [RULE_05]
            oe_n_q <= 1'b1; // [RULE_02]
          end
        end
        ST_GAP: begin
          ce_n_q <= 1'b1;
          if (tmr_done) begin
            dq_oe_q <= 1'b0;
            // Select again for the next poll read; toggle counts per read
            if (cmd_q == EPW_CMD_POLL && !done_q) ce_n_q <= 1'b0; // [RULE_16]
          end
        end
        default: begin
          ce_n_q <= 1'b1;
          oe_n_q <= 1'b1;
          we_n_q <= 1'b1;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Page tracking

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      in_page_q   <= 1'b0;
      page_q      <= '0;
      last_data_q <= '0;
      last_q      <= 1'b0;
      page_err_q  <= 1'b0;
    end else if (st_q == ST_IDLE && req_valid && req_ready_q
                 && req.cmd == EPW_CMD_WRITE) begin
      in_page_q   <= 1'b1; // [RULE_07] [RULE_10]
      last_data_q <= req.data;
      last_q      <= req.last;
      page_q      <= req.addr[ADDR_W-1:PAGE_LSB];
      // Flag a page mix-up; the device's destination would be undefined
      page_err_q  <= in_page_q &&
                     (req.addr[ADDR_W-1:PAGE_LSB] != page_q); // [RULE_08] [RULE_18]
    end else if (st_q == ST_POLL) begin
      in_page_q <= 1'b0; // [RULE_06]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Completion detection from polled reads

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rsp_valid_q <= 1'b0;
      rsp_data_q  <= '0;
      done_q      <= 1'b1;
      prev_rd_q   <= '0;
      have_prev_q <= 1'b0;
    end else begin
      rsp_valid_q <= 1'b0;
      if (st_q == ST_POLL) begin
        done_q      <= 1'b0;
        have_prev_q <= 1'b0;
      end else if (st_q == ST_RACC && tmr_done) begin
        rsp_data_q  <= dq_in;
        prev_rd_q   <= dq_in;
        have_prev_q <= 1'b1;
        if (cmd_q == EPW_CMD_POLL) begin
          // Done when bit 7 is true and bit 6 stopped; a blocked write
          // gets no case of its own, so bit 7 must match then as well
          if (dq_in[BIT7_POS] == last_data_q[BIT7_POS] &&
              have_prev_q &&
              dq_in[BIT6_POS] == prev_rd_q[BIT6_POS]) begin
            done_q      <= 1'b1; // [RULE_13] [RULE_14] [RULE_15]
            rsp_valid_q <= 1'b1; // [RULE_16] [RULE_17] [RULE_20] [RULE_21]
          end
        end else begin
          rsp_valid_q <= 1'b1;
        end
      end
    end
  end

  logic unused_last;
  assign unused_last = last_q;

endmodule
`default_nettype wire

// ==== verilog/epw_pkg.sv ====
// Package for the parallel EEPROM host controller: pin bundles,
// command encodings and timing counts.
// Assumes a 40 MHz system clock.
package epw_pkg;

  localparam int unsigned CLK_MHZ          = 40;
  localparam int unsigned ADDR_W           = 13;
  localparam int unsigned DATA_W           = 8;
  localparam int unsigned PAGE_BYTES       = 64;
  localparam int unsigned BYTE_ADDR_W      = 6;
  localparam int unsigned PAGE_LSB         = 6;
  localparam int unsigned BIT7_POS         = 7;
  localparam int unsigned BIT6_POS         = 6;
  // Strobe and setup phase lengths, in ns
  localparam int unsigned ACCESS_NS        = 350;
  localparam int unsigned WE_PULSE_NS      = 100;
  localparam int unsigned SETUP_NS         = 50;
  localparam int unsigned GAP_NS           = 200;
  // Byte load window, in us
  localparam int unsigned LOAD_WINDOW_US   = 150;
  localparam int unsigned ACCESS_CYC  = (ACCESS_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned WE_PULSE_CYC = (WE_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned SETUP_CYC   = (SETUP_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned GAP_CYC     = (GAP_NS * CLK_MHZ + 999) / 1000;
  // Longest time: round down
  localparam int unsigned LOAD_WINDOW_CYC = LOAD_WINDOW_US * CLK_MHZ;
  localparam int unsigned CNT_W = 16;

  typedef enum logic [1:0] {
    EPW_CMD_READ  = 2'h0,
    EPW_CMD_WRITE = 2'h1,
    EPW_CMD_POLL  = 2'h2
  } epw_cmd_e;

  typedef struct packed {
    epw_cmd_e            cmd;
    logic [ADDR_W-1:0]   addr;
    logic [DATA_W-1:0]   data;
    logic                last;
  } epw_req_s;

  typedef struct packed {
    logic                ce_n;
    logic                oe_n;
    logic                we_n;
    logic [ADDR_W-1:0]   addr;
    logic [DATA_W-1:0]   dq_out;
    logic                dq_oe;
  } epw_pins_s;

endpackage
